// File: dacc_top.sv
// Control of two voltage-output converters behind the register space.
// Assumes one core clock, asynchronous active-low reset, and a register
// port that gives at most one read or write per cycle on that clock.
//
// Notes on behaviour
// R1: Control bit 7 high means 8-bit mode, code from low byte only.
// R2: Control bit 6 picks supply range for converter 1 when high.
// R3: Control bit 5 picks supply range for converter 0 when high.
// R4: Clear bits 4 and 3 low force converter 1 and 0 codes to zero.
// R5: With sync bit 2 high, a low byte write updates that output.
// R6: Sync low holds writes; setting sync updates both outputs together.
// R7: Control bit 1 powers converter 1 on when high.
// R8: Control bit 0 powers converter 0 on when high.
// R9: Control register resets to 04 hex.
// R10: Software writes high byte before low byte in immediate mode.
// R11: Code is right-justified: low byte bits 7-0, high nibble bits 11-8.
// R12: Four data byte registers reset to zero and are writable.
// R13: Configuration bit 5 high bypasses the output buffers.
// R14: Configuration resets to zero; reserved bits 3 to 1 stay zero.
// R15: After reset both converters are off, outputs high impedance.
// R16: High byte upper nibble ignored; high byte unused in 8-bit mode.
`timescale 1ns/1ps
`include "dacc_params.svh"
module dacc_top
    import dacc_pkg::*;
#(
    parameter int CODE_W = 12,
    parameter int BYTE_W = 8
)
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire dacc_sfr_t sfr_req,
    output logic [BYTE_W-1:0] sfr_rdata_q,
    output dacc_chan_t chan0_q,
    output dacc_chan_t chan1_q
);

    logic [BYTE_W-1:0] ctrl_q;
    logic [BYTE_W-1:0] ctrl_d;
    logic [BYTE_W-1:0] cfg_q;
    logic [BYTE_W-1:0] cfg_d;
    logic [BYTE_W-1:0] sfr_rdata_d;
    logic [BYTE_W-1:0] low0;
    logic [BYTE_W-1:0] high0;
    logic [BYTE_W-1:0] low1;
    logic [BYTE_W-1:0] high1;
    logic wr_ctrl;
    logic wr_cfg;
    logic wr_lo0;
    logic wr_hi0;
    logic wr_lo1;
    logic wr_hi1;
    logic sync_rise;

    ////////////////////////////////////////////////////////////////////////
    // Address decode; same-clock register port, so no synchronisers
    assign wr_ctrl = sfr_req.wr && (sfr_req.addr == `DACC_ADDR_CTRL);
    assign wr_cfg = sfr_req.wr && (sfr_req.addr == `DACC_ADDR_CFG);
    assign wr_lo0 = sfr_req.wr && (sfr_req.addr == `DACC_ADDR_LO0);
    assign wr_hi0 = sfr_req.wr && (sfr_req.addr == `DACC_ADDR_HI0);
    assign wr_lo1 = sfr_req.wr && (sfr_req.addr == `DACC_ADDR_LO1);
    assign wr_hi1 = sfr_req.wr && (sfr_req.addr == `DACC_ADDR_HI1);

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        ctrl_d = ctrl_q;
        cfg_d = cfg_q;
        if (wr_ctrl)
        begin
            ctrl_d = sfr_req.wdata;
        end
        if (wr_cfg)
        begin
            // Reserved bits kept at zero whatever is written
            cfg_d = sfr_req.wdata & `DACC_CFG_WR_MASK; // R14
        end
        sfr_rdata_d = sfr_rdata_q;
        if (sfr_req.rd)
        begin
            case (sfr_req.addr)
                `DACC_ADDR_CTRL: sfr_rdata_d = ctrl_q;
                `DACC_ADDR_CFG: sfr_rdata_d = cfg_q;
                `DACC_ADDR_LO0: sfr_rdata_d = low0;
                `DACC_ADDR_HI0: sfr_rdata_d = high0;
                `DACC_ADDR_LO1: sfr_rdata_d = low1;
                `DACC_ADDR_HI1: sfr_rdata_d = high1;
                default: sfr_rdata_d = `DACC_UNMAPPED_RD;
            endcase
        end
    end

    // Only a 0 to 1 change updates; rewriting 1 leaves outputs alone
    assign sync_rise = !ctrl_q[`DACC_CTRL_SYNC]
                       && ctrl_d[`DACC_CTRL_SYNC]; // R6

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_q <= `DACC_CTRL_RST; // R9 R15
            cfg_q <= `DACC_CFG_RST; // R14
            sfr_rdata_q <= `DACC_UNMAPPED_RD;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            cfg_q <= cfg_d;
            sfr_rdata_q <= sfr_rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel slices see the new mode, clear, power and range bits in the write cycle (sync_now is the registered bit), so
    // the mode and clear bits written together with sync take effect.
    dacc_channel #(
        .CODE_W(CODE_W),
        .BYTE_W(BYTE_W)
    ) u_chan0 (
        .core_clk(core_clk),
        .resetn(resetn),
        .wr_low(wr_lo0),
        .wr_high(wr_hi0),
        .wdata(sfr_req.wdata),
        .mode8(ctrl_d[`DACC_CTRL_MODE]), // R1
        .sync_now(ctrl_q[`DACC_CTRL_SYNC]), // R5
        .sync_rise(sync_rise),
        .force_zero_n(ctrl_d[`DACC_CTRL_FORCE_ZERO_N_CH0]), // R4
        .power_on(ctrl_d[`DACC_CTRL_PWR0]), // R8
        .range_select(ctrl_d[`DACC_CTRL_RANGE_SELECT_CH0]), // R3
        .buffer_bypass(cfg_d[`DACC_CFG_BUF_BYP]), // R13
        .low_q(low0),
        .high_q(high0),
        .chan_q(chan0_q)
    );

    dacc_channel #(
        .CODE_W(CODE_W),
        .BYTE_W(BYTE_W)
    ) u_chan1 (
        .core_clk(core_clk),
        .resetn(resetn),
        .wr_low(wr_lo1),
        .wr_high(wr_hi1),
        .wdata(sfr_req.wdata),
        .mode8(ctrl_d[`DACC_CTRL_MODE]), // R1
        .sync_now(ctrl_q[`DACC_CTRL_SYNC]), // R5
        .sync_rise(sync_rise),
        .force_zero_n(ctrl_d[`DACC_CTRL_FORCE_ZERO_N_CH1]), // R4
        .power_on(ctrl_d[`DACC_CTRL_PWR1]), // R7
        .range_select(ctrl_d[`DACC_CTRL_RANGE_SELECT_CH1]), // R2
        .buffer_bypass(cfg_d[`DACC_CFG_BUF_BYP]), // R13
        .low_q(low1),
        .high_q(high1),
        .chan_q(chan1_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic seen_q;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            seen_q <= 1'h0;
        end
        else
        begin
            seen_q <= 1'h1;
        end
    end

    property p_mode8;
        @(posedge core_clk) disable iff (!resetn)
        (wr_lo0 && ctrl_q[`DACC_CTRL_SYNC] && ctrl_q[`DACC_CTRL_MODE]
         && ctrl_q[`DACC_CTRL_FORCE_ZERO_N_CH0])
        |=> chan0_q.code == {$past(sfr_req.wdata), 4'h0};
    endproperty
    a_mode8: assert property (p_mode8) // R1 R16
        else $error("8-bit code not taken from low byte");

    property p_range1;
        @(posedge core_clk) disable iff (!resetn)
        wr_ctrl |=> chan1_q.range_select
                    == $past(sfr_req.wdata[`DACC_CTRL_RANGE_SELECT_CH1]);
    endproperty
    a_range1: assert property (p_range1) // R2
        else $error("Converter 1 range not following control write");

    property p_range0;
        @(posedge core_clk) disable iff (!resetn)
        chan0_q.range_select == ctrl_q[`DACC_CTRL_RANGE_SELECT_CH0];
    endproperty
    a_range0: assert property (p_range0) // R3
        else $error("Converter 0 range differs from control");

    property p_clear;
        @(posedge core_clk) disable iff (!resetn)
        (!ctrl_q[`DACC_CTRL_FORCE_ZERO_N_CH1] |-> chan1_q.code == '0)
        and (!ctrl_q[`DACC_CTRL_FORCE_ZERO_N_CH0] |-> chan0_q.code == '0);
    endproperty
    a_clear: assert property (p_clear) // R4
        else $error("Cleared converter code not zero");

    property p_immediate;
        @(posedge core_clk) disable iff (!resetn)
        (wr_lo1 && ctrl_q[`DACC_CTRL_SYNC] && !ctrl_q[`DACC_CTRL_MODE]
         && ctrl_q[`DACC_CTRL_FORCE_ZERO_N_CH1])
        |=> chan1_q.code == {$past(high1[3:0]), $past(sfr_req.wdata)};
    endproperty
    a_immediate: assert property (p_immediate) // R5 R11 R16
        else $error("Immediate 12-bit update wrong");

    property p_hold;
        @(posedge core_clk) disable iff (!resetn)
        ((wr_lo0 || wr_hi0 || wr_lo1 || wr_hi1)
         && !ctrl_q[`DACC_CTRL_SYNC])
        |=> $stable(chan0_q.code) && $stable(chan1_q.code);
    endproperty
    a_hold: assert property (p_hold) // R6
        else $error("Output moved while updates held");

    property p_sync_both;
        @(posedge core_clk) disable iff (!resetn)
        (wr_ctrl && !ctrl_q[`DACC_CTRL_SYNC]
         && sfr_req.wdata[`DACC_CTRL_SYNC]
         && !sfr_req.wdata[`DACC_CTRL_MODE]
         && sfr_req.wdata[`DACC_CTRL_FORCE_ZERO_N_CH0]
         && sfr_req.wdata[`DACC_CTRL_FORCE_ZERO_N_CH1])
        |=> chan0_q.code == {$past(high0[3:0]), $past(low0)}
            && chan1_q.code == {$past(high1[3:0]), $past(low1)};
    endproperty
    a_sync_both: assert property (p_sync_both) // R6
        else $error("Held values not applied together");

    property p_power;
        @(posedge core_clk) disable iff (!resetn)
        chan1_q.power_on == ctrl_q[`DACC_CTRL_PWR1]
        && chan0_q.power_on == ctrl_q[`DACC_CTRL_PWR0];
    endproperty
    a_power: assert property (p_power) // R7 R8
        else $error("Power enable differs from control");

    property p_reset_state;
        @(posedge core_clk) disable iff (!resetn)
        !seen_q |-> ctrl_q == `DACC_CTRL_RST && cfg_q == `DACC_CFG_RST
                    && low0 == `DACC_DATA_RST && high1 == `DACC_DATA_RST
                    && !chan0_q.power_on && !chan1_q.power_on;
    endproperty
    a_reset_state: assert property (p_reset_state) // R9 R12 R14 R15
        else $error("Wrong state after reset release");

    property p_readback;
        @(posedge core_clk) disable iff (!resetn)
        wr_hi0 ##1 (sfr_req.rd && sfr_req.addr == `DACC_ADDR_HI0)
        |=> sfr_rdata_q == $past(sfr_req.wdata, 2);
    endproperty
    a_readback: assert property (p_readback) // R12
        else $error("Data byte readback wrong");

    property p_bypass;
        @(posedge core_clk) disable iff (!resetn)
        wr_cfg |=> chan0_q.buffer_bypass
                   == $past(sfr_req.wdata[`DACC_CFG_BUF_BYP])
                   && chan1_q.buffer_bypass == chan0_q.buffer_bypass;
    endproperty
    a_bypass: assert property (p_bypass) // R13
        else $error("Buffer bypass not following configuration");

    property p_reserved;
        @(posedge core_clk) disable iff (!resetn)
        cfg_q[`DACC_CFG_RSVD_HI:`DACC_CFG_RSVD_LO] == '0;
    endproperty
    a_reserved: assert property (p_reserved) // R14
        else $error("Reserved configuration bits set");

    property p_sync_mode8;
        @(posedge core_clk) disable iff (!resetn)
        (wr_ctrl && !ctrl_q[`DACC_CTRL_SYNC]
         && sfr_req.wdata[`DACC_CTRL_SYNC]
         && sfr_req.wdata[`DACC_CTRL_MODE]
         && sfr_req.wdata[`DACC_CTRL_FORCE_ZERO_N_CH0]
         && sfr_req.wdata[`DACC_CTRL_FORCE_ZERO_N_CH1])
        |=> chan0_q.code == {$past(low0), 4'h0}
            && chan1_q.code == {$past(low1), 4'h0};
    endproperty
    a_sync_mode8: assert property (p_sync_mode8) // R1 R6 R16
        else $error("Held 8-bit values not applied together");

    property p_data_wr;
        @(posedge core_clk) disable iff (!resetn)
        (wr_lo0 |=> low0 == $past(sfr_req.wdata))
        and (wr_hi1 |=> high1 == $past(sfr_req.wdata));
    endproperty
    a_data_wr: assert property (p_data_wr) // R12
        else $error("Data byte write not stored");

    property p_reset_data;
        @(posedge core_clk) disable iff (!resetn)
        !seen_q |-> high0 == `DACC_DATA_RST && low1 == `DACC_DATA_RST
                    && chan0_q.code == '0 && chan1_q.code == '0;
    endproperty
    a_reset_data: assert property (p_reset_data) // R12 R15
        else $error("Data bytes or codes not clear after reset");

    // Unmapped reads answer a fixed value rather than stale data
    property p_unmapped_rd;
        @(posedge core_clk) disable iff (!resetn)
        (sfr_req.rd && !(sfr_req.addr inside {`DACC_ADDR_CFG,
            `DACC_ADDR_LO0, `DACC_ADDR_HI0, `DACC_ADDR_LO1,
            `DACC_ADDR_HI1, `DACC_ADDR_CTRL}))
        |=> sfr_rdata_q == `DACC_UNMAPPED_RD;
    endproperty
    a_unmapped_rd: assert property (p_unmapped_rd)
        else $error("Unmapped read not returning fixed value");

endmodule

// File: dacc_params.svh
// Register map, field positions and reset values of the converter control.
// Assumes an 8-bit special-function register space on the core clock.
`ifndef DACC_PARAMS_SVH
`define DACC_PARAMS_SVH

`define DACC_ADDR_CFG 8'hAF
`define DACC_ADDR_LO0 8'hF9
`define DACC_ADDR_HI0 8'hFA
`define DACC_ADDR_LO1 8'hFB
`define DACC_ADDR_HI1 8'hFC
`define DACC_ADDR_CTRL 8'hFD

`define DACC_CTRL_RST 8'h04
`define DACC_CFG_RST 8'h00
`define DACC_DATA_RST 8'h00
`define DACC_UNMAPPED_RD 8'h00

`define DACC_CTRL_MODE 7
`define DACC_CTRL_RANGE_SELECT_CH1 6
`define DACC_CTRL_RANGE_SELECT_CH0 5
`define DACC_CTRL_FORCE_ZERO_N_CH1 4
`define DACC_CTRL_FORCE_ZERO_N_CH0 3
`define DACC_CTRL_SYNC 2
`define DACC_CTRL_PWR1 1
`define DACC_CTRL_PWR0 0

`define DACC_CFG_BUF_BYP 5
`define DACC_CFG_RSVD_HI 3
`define DACC_CFG_RSVD_LO 1
`define DACC_CFG_WR_MASK 8'hF1

`endif

// File: dacc_pkg.sv
// Types shared by the converter control and its channel slices.
// Assumes 8-bit register data and 12-bit converter codes.
package dacc_pkg;

    typedef struct packed
    {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } dacc_sfr_t;

    typedef struct packed
    {
        logic [11:0] code;
        logic power_on;
        logic range_select;
        logic buffer_bypass;
    } dacc_chan_t;

endpackage

// File: dacc_channel.sv
// One converter slice: data byte pair, update register and analog controls.
// Assumes the control decode arrives as same-clock strobes and levels.
`timescale 1ns/1ps
`include "dacc_params.svh"
module dacc_channel
    import dacc_pkg::*;
#(
    parameter int CODE_W = 12,
    parameter int BYTE_W = 8
)
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic wr_low,
    input wire logic wr_high,
    input wire logic [BYTE_W-1:0] wdata,
    input wire logic mode8,
    input wire logic sync_now,
    input wire logic sync_rise,
    input wire logic force_zero_n,
    input wire logic power_on,
    input wire logic range_select,
    input wire logic buffer_bypass,
    output logic [BYTE_W-1:0] low_q,
    output logic [BYTE_W-1:0] high_q,
    output dacc_chan_t chan_q
);

    localparam int NIB_W = CODE_W - BYTE_W;

    logic [BYTE_W-1:0] low_d;
    logic [BYTE_W-1:0] high_d;
    logic [CODE_W-1:0] code_q;
    logic [CODE_W-1:0] code_d;
    dacc_chan_t chan_d;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        low_d = low_q;
        high_d = high_q;
        code_d = code_q;
        if (wr_low)
        begin
            low_d = wdata; // R12
        end
        if (wr_high)
        begin
            high_d = wdata; // R12
        end
        // Upper nibble of the high byte never reaches the code
        if (wr_low && sync_now)
        begin
            code_d = mode8 ? {wdata, {NIB_W{1'h0}}} // R1 R16
                           : {high_q[NIB_W-1:0], wdata}; // R5 R11
        end
        else if (sync_rise)
        begin
            code_d = mode8 ? {low_q, {NIB_W{1'h0}}} // R6 R16
                           : {high_q[NIB_W-1:0], low_q}; // R6 R11
        end
        chan_d.code = force_zero_n ? code_d : '0; // R4
        chan_d.power_on = power_on; // R7 R8 R15
        chan_d.range_select = range_select; // R2 R3
        chan_d.buffer_bypass = buffer_bypass; // R13
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            low_q <= `DACC_DATA_RST;
            high_q <= `DACC_DATA_RST;
            code_q <= '0;
            chan_q <= '0;
        end
        else
        begin
            low_q <= low_d;
            high_q <= high_d;
            code_q <= code_d;
            chan_q <= chan_d;
        end
    end

endmodule

// File: tb_top.sv
// Self-checking bench for the two-converter control block.
// Assumes the register port is driven directly; requests are spaced,
// apart from one back-to-back write and read.
`timescale 1ns/1ps
`include "dacc_params.svh"
module tb_top
    import dacc_pkg::*;
;
    logic core_clk;
    logic resetn;
    dacc_sfr_t sfr_req;
    logic [7:0] sfr_rdata_q;
    dacc_chan_t chan0_q;
    dacc_chan_t chan1_q;
    int error_cnt;
    int num_checks;
    logic [7:0] rd_val;

    dacc_top u_dut
    (
        .core_clk(core_clk),
        .resetn(resetn),
        .sfr_req(sfr_req),
        .sfr_rdata_q(sfr_rdata_q),
        .chan0_q(chan0_q),
        .chan1_q(chan1_q)
    );

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobe raised on one edge, taken and lowered on the next
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge core_clk);
        sfr_req <= '0;
        @(posedge core_clk);
        #1;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        sfr_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge core_clk);
        sfr_req <= '0;
        @(posedge core_clk);
        #1;
        d = sfr_rdata_q;
    endtask

    task automatic chk8(input string n, input logic [7:0] e,
        input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_ch(input string n, input dacc_chan_t e,
        input dacc_chan_t g);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        rd_reg(a, rd_val);
        chk8("read data", e, rd_val);
    endtask

    function automatic dacc_chan_t mk(input logic [11:0] c,
        input logic p, input logic r, input logic b);
        mk = '{code: c, power_on: p, range_select: r, buffer_bypass: b};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk_rd(`DACC_ADDR_CTRL, 8'h04);
        chk_rd(`DACC_ADDR_CFG, 8'h00);
        chk_rd(`DACC_ADDR_LO0, 8'h00);
        chk_rd(`DACC_ADDR_HI0, 8'h00);
        chk_rd(`DACC_ADDR_LO1, 8'h00);
        chk_rd(`DACC_ADDR_HI1, 8'h00);
        chk_rd(8'h10, 8'h00);
        chk_ch("chan0", mk(12'h000, 1'b0, 1'b0, 1'b0), chan0_q);
        chk_ch("chan1", mk(12'h000, 1'b0, 1'b0, 1'b0), chan1_q);
    endtask

    // Immediate mode, high byte first; upper nibble must not leak
    task automatic t_immediate();
        wr_reg(`DACC_ADDR_CTRL, 8'h1D);
        chk_ch("chan1", mk(12'h000, 1'b0, 1'b0, 1'b0), chan1_q);
        wr_reg(`DACC_ADDR_CTRL, 8'h1E);
        chk_ch("chan0", mk(12'h000, 1'b0, 1'b0, 1'b0), chan0_q);
        wr_reg(`DACC_ADDR_CTRL, 8'h1F);
        wr_reg(`DACC_ADDR_HI0, 8'hF5);
        chk_ch("chan0", mk(12'h000, 1'b1, 1'b0, 1'b0), chan0_q);
        wr_reg(`DACC_ADDR_LO0, 8'hA3);
        chk_ch("chan0", mk(12'h5A3, 1'b1, 1'b0, 1'b0), chan0_q);
        wr_reg(`DACC_ADDR_HI1, 8'h02);
        wr_reg(`DACC_ADDR_LO1, 8'h4C);
        chk_ch("chan1", mk(12'h24C, 1'b1, 1'b0, 1'b0), chan1_q);
        chk_rd(`DACC_ADDR_HI0, 8'hF5);
    endtask

    task automatic t_range();
        wr_reg(`DACC_ADDR_CTRL, 8'h5F);
        chk_ch("chan1", mk(12'h24C, 1'b1, 1'b1, 1'b0), chan1_q);
        chk_ch("chan0", mk(12'h5A3, 1'b1, 1'b0, 1'b0), chan0_q);
        wr_reg(`DACC_ADDR_CTRL, 8'h3F);
        chk_ch("chan0", mk(12'h5A3, 1'b1, 1'b1, 1'b0), chan0_q);
        chk_ch("chan1", mk(12'h24C, 1'b1, 1'b0, 1'b0), chan1_q);
    endtask

    task automatic t_clear();
        wr_reg(`DACC_ADDR_CTRL, 8'h17);
        chk_ch("chan0", mk(12'h000, 1'b1, 1'b0, 1'b0), chan0_q);
        chk_ch("chan1", mk(12'h24C, 1'b1, 1'b0, 1'b0), chan1_q);
        wr_reg(`DACC_ADDR_CTRL, 8'h0F);
        chk_ch("chan1", mk(12'h000, 1'b1, 1'b0, 1'b0), chan1_q);
        wr_reg(`DACC_ADDR_CTRL, 8'h1F);
        chk_ch("chan0", mk(12'h5A3, 1'b1, 1'b0, 1'b0), chan0_q);
    endtask

    // Held writes must stay invisible until the sync bit rises
    task automatic t_sync();
        wr_reg(`DACC_ADDR_CTRL, 8'h1B);
        wr_reg(`DACC_ADDR_HI0, 8'h03);
        wr_reg(`DACC_ADDR_LO0, 8'h11);
        wr_reg(`DACC_ADDR_HI1, 8'h0E);
        wr_reg(`DACC_ADDR_LO1, 8'hFF);
        chk_ch("chan0", mk(12'h5A3, 1'b1, 1'b0, 1'b0), chan0_q);
        chk_ch("chan1", mk(12'h24C, 1'b1, 1'b0, 1'b0), chan1_q);
        @(posedge core_clk);
        sfr_req <= '{addr: `DACC_ADDR_CTRL, wr: 1'b1, rd: 1'b0,
            wdata: 8'h1F};
        @(posedge core_clk);
        sfr_req <= '0;
        @(posedge core_clk);
        #1;
        chk_ch("chan0", mk(12'h311, 1'b1, 1'b0, 1'b0), chan0_q);
        chk_ch("chan1", mk(12'hEFF, 1'b1, 1'b0, 1'b0), chan1_q);
    endtask

    task automatic t_mode8();
        wr_reg(`DACC_ADDR_CTRL, 8'h9F);
        wr_reg(`DACC_ADDR_LO0, 8'hC7);
        chk_ch("chan0", mk(12'hC70, 1'b1, 1'b0, 1'b0), chan0_q);
        wr_reg(`DACC_ADDR_CTRL, 8'h9B);
        wr_reg(`DACC_ADDR_LO1, 8'h5E);
        chk_ch("chan1", mk(12'hEFF, 1'b1, 1'b0, 1'b0), chan1_q);
        wr_reg(`DACC_ADDR_CTRL, 8'h9F);
        chk_ch("chan1", mk(12'h5E0, 1'b1, 1'b0, 1'b0), chan1_q);
        chk_ch("chan0", mk(12'hC70, 1'b1, 1'b0, 1'b0), chan0_q);
        chk_rd(`DACC_ADDR_CTRL, 8'h9F);
    endtask

    task automatic t_config();
        wr_reg(`DACC_ADDR_CFG, 8'hFF);
        chk_rd(`DACC_ADDR_CFG, 8'hF1);
        chk8("bypass0", 8'h01, {7'h00, chan0_q.buffer_bypass});
        chk8("bypass1", 8'h01, {7'h00, chan1_q.buffer_bypass});
        wr_reg(`DACC_ADDR_CFG, 8'h00);
        chk8("bypass0", 8'h00, {7'h00, chan0_q.buffer_bypass});
        wr_reg(8'h10, 8'hFF);
        chk_rd(`DACC_ADDR_CTRL, 8'h9F);
        wr_reg(`DACC_ADDR_CTRL, 8'h9C);
        chk8("power0", 8'h00, {7'h00, chan0_q.power_on});
        chk8("power1", 8'h00, {7'h00, chan1_q.power_on});
    endtask

    // Write then read on consecutive cycles; read sees the new byte
    task automatic t_back2back();
        @(posedge core_clk);
        sfr_req <= '{addr: `DACC_ADDR_HI0, wr: 1'b1, rd: 1'b0,
            wdata: 8'hA6};
        @(posedge core_clk);
        sfr_req <= '{addr: `DACC_ADDR_HI0, wr: 1'b0, rd: 1'b1,
            wdata: 8'h00};
        @(posedge core_clk);
        sfr_req <= '0;
        @(posedge core_clk);
        #1;
        chk8("hi0 back to back", 8'hA6, sfr_rdata_q);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Whole run is about 125 cycles; this bound is far beyond it
    initial
    begin
        #100000;
        error_cnt++;
        give_verdict();
    end

    initial
    begin
        error_cnt = 0;
        num_checks = 0;
        resetn = 1'b0;
        sfr_req = '0;
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset();
        t_immediate();
        t_range();
        t_clear();
        t_sync();
        t_mode8();
        t_config();
        t_back2back();
        give_verdict();
    end
endmodule
